// ==== design/dispif_pkg.sv ====
package dispif_pkg;

  // ----------------------------------------
  // Clock rates
  // ----------------------------------------
  localparam int CORE_CLOCK_KHZ = 50000;
  localparam int PIXEL_CLOCK_KHZ = 27000;
  localparam logic [16:0] PIX_STEP = 17'(PIXEL_CLOCK_KHZ);
  localparam logic [16:0] PIX_WRAP = 17'(CORE_CLOCK_KHZ);

  // ----------------------------------------
  // Counts and sizes
  // ----------------------------------------
  localparam int PAUSE_MIN_CYC = 4;
  localparam int PAUSE_MAX_CYC = 19;
  localparam logic [4:0] PAUSE_BASE = 5'(PAUSE_MIN_CYC);
  localparam int FIFO_DEPTH_DEF = 8;
  localparam int DATA_W_DEF = 16;
  localparam int BE_W = 2;
  localparam int ENT_XTRA = 2 + BE_W;

  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam logic RST_INACTIVE = 1'b1;
  localparam logic [1:0] RST_BE_N = 2'b11;

  // ----------------------------------------
  // Modes and states
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_TV = 2'b01,
    MODE_PAR = 2'b10
  } if_mode_e;

  typedef enum logic [1:0] {
    BURST_PLAIN = 2'b00,
    BURST_CLOCKED = 2'b01,
    BURST_SINGLE = 2'b10
  } burst_mode_e;

  typedef enum logic [2:0] {
    P_IDLE = 3'b000,
    P_ACCESS = 3'b001,
    P_HOLD = 3'b010,
    P_GAP = 3'b011,
    P_PAUSE = 3'b100
  } par_state_e;

endpackage

// ==== design/display_port.sv ====
// ----------------------------------------
// Data FIFO
// ----------------------------------------
module disp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("FIFO depth must be a power of two");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic ready_q;
  logic push;
  logic pop;

  assign push = in_valid_i && ready_q;
  assign pop = out_ready_i && (cnt_q != '0);
  assign in_ready_o = ready_q;
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ready_q <= 1'b1;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_d;
      ready_q <= (cnt_d != (AW + 1)'(DEPTH));
    end
  end
endmodule

// Overview of operation
// - One eight-bit component per pixel clock
// - Component bits 7..0 on lanes 17..10
// - Pixel clock averages 27 MHz
// - Line, field and valid strobes active low
// - Line sync low one pixel per row
// - Field sync low one or more pixels
// - Odd field edges coincide, even ones not
// - Pixel data only while line sync high
// - System 80/68k, type 1/2, byte enables
// - Source marks burst length with last flag
// - Type 1: select qualifies, direction lines steady
// - Type 2: strobes qualify, select held
// - Clocked burst: burst clock qualifies, select held
// - Clocked burst end: all controls inactive
// - Single access: one idle period between
// - Pause of 4 to 19 cycles between bursts
// - Read wait states stretch read to two, three or four periods
// - Control polarity programmable, active low reference
// - Read strobe between up and down points
// - Write strobe between up and down points
// - Period is ceiling of setting over clock setting
// - Up and down points rounded up halves
module display_port
  import dispif_pkg::*;
#(
  parameter int DATA_W = DATA_W_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Configuration
  input wire logic [1:0] if_mode_i,
  input wire logic par_style_68k_i,
  input wire logic par_type2_i,
  input wire logic [1:0] burst_mode_i,
  input wire logic use_byte_en_i,
  input wire logic [3:0] signal_polarity_control_i,
  input wire logic [3:0] pause_setting_i,
  input wire logic [1:0] read_wait_setting_i,
  // Access timing
  input wire logic [7:0] core_clock_period_setting_i,
  input wire logic [11:0] read_period_setting_i,
  input wire logic [11:0] write_period_setting_i,
  input wire logic [10:0] read_up_setting_i,
  input wire logic [10:0] read_down_setting_i,
  input wire logic [10:0] write_up_setting_i,
  input wire logic [10:0] write_down_setting_i,
  input wire logic [11:0] read_point_setting_i,
  // TV raster
  input wire logic [11:0] tv_line_total_i,
  input wire logic [11:0] tv_active_first_i,
  input wire logic [11:0] tv_active_count_i,
  input wire logic [10:0] tv_field_lines_i,
  input wire logic [7:0] tv_field_sync_width_i,
  // Source stream
  input wire logic src_valid_i,
  output logic src_ready_o,
  input wire logic [DATA_W-1:0] src_data_i,
  input wire logic src_read_i,
  input wire logic src_last_i,
  input wire logic [BE_W-1:0] src_be_i,
  // Read return
  output logic rd_valid_o,
  output logic [DATA_W-1:0] rd_data_o,
  // TV encoder pins
  output logic tv_pixel_clock_o,
  output logic line_sync_out_o,
  output logic field_sync_out_o,
  output logic pixel_valid_out_o,
  output logic [17:10] tv_data_lanes_o,
  // Parallel port pins
  output logic display_select_n_o,
  output logic write_strobe_n_o,
  output logic read_strobe_n_o,
  output logic burst_clock_out_o,
  output logic [BE_W-1:0] byte_enable_n_o,
  input wire logic [DATA_W-1:0] par_data_i,
  output logic [DATA_W-1:0] par_data_o,
  output logic par_data_oe_o
);
  localparam int EW = DATA_W + ENT_XTRA;

  if (DATA_W < 8 || DATA_W > 32) begin : g_chk
    $error("DATA_W must lie between 8 and 32");
  end

  // ----------------------------------------
  // Data FIFO
  // ----------------------------------------
  logic f_valid;
  logic f_ready;
  logic [EW-1:0] f_data;
  logic f_last;
  logic f_rd;
  logic [BE_W-1:0] f_be;
  logic [DATA_W-1:0] f_word;

  assign {f_last, f_rd, f_be, f_word} = f_data;

  disp_fifo #(.WIDTH(EW), .DEPTH(FIFO_DEPTH)) disp_fifo_i (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(src_valid_i),
    .in_ready_o(src_ready_o),
    .in_data_i({src_last_i, src_read_i, src_be_i, src_data_i}),
    .out_valid_o(f_valid),
    .out_ready_i(f_ready),
    .out_data_o(f_data)
  );

  // ----------------------------------------
  // Pixel clock enable
  // ----------------------------------------
  logic [16:0] acc_q;
  logic [16:0] acc_sum;
  logic pix_en_q;
  logic tv_on;

  assign tv_on = (if_mode_i == MODE_TV);
  assign acc_sum = acc_q + PIX_STEP;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i || !tv_on) begin
      acc_q <= '0;
      pix_en_q <= 1'b0;
    end else if (acc_sum >= PIX_WRAP) begin
      acc_q <= acc_sum - PIX_WRAP;
      pix_en_q <= 1'b1;
    end else begin
      acc_q <= acc_sum;
      pix_en_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // TV raster
  // ----------------------------------------
  logic [11:0] h_q;
  logic [10:0] v_q;
  logic odd_q;
  logic out_odd_q;
  logic [7:0] vs_cnt_q;
  logic [11:0] half_c;
  logic vs_start;
  logic tv_win;
  logic tv_pop;

  assign half_c = (tv_line_total_i[11:1] == '0) ? 12'h001 : {1'b0, tv_line_total_i[11:1]};
  assign vs_start = (v_q == '0) && (odd_q ? (h_q == '0) : (h_q == half_c));
  assign tv_win = (h_q != '0) && (h_q >= tv_active_first_i)
    && ({1'b0, h_q} < {1'b0, tv_active_first_i} + {1'b0, tv_active_count_i});
  assign tv_pop = pix_en_q && tv_on && tv_win && f_valid;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i || !tv_on) begin
      h_q <= '0;
      v_q <= '0;
      odd_q <= 1'b1;
    end else if (pix_en_q) begin
      if (h_q >= tv_line_total_i - 12'h001) begin
        h_q <= '0;
        if (v_q >= tv_field_lines_i - 11'h001) begin
          v_q <= '0;
          odd_q <= !odd_q;
        end else begin
          v_q <= v_q + 11'h001;
        end
      end else begin
        h_q <= h_q + 12'h001;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      tv_pixel_clock_o <= 1'b0;
      line_sync_out_o <= RST_INACTIVE;
      field_sync_out_o <= RST_INACTIVE;
      pixel_valid_out_o <= RST_INACTIVE;
      tv_data_lanes_o <= '0;
      vs_cnt_q <= '0;
      out_odd_q <= 1'b1;
    end else if (!tv_on) begin
      tv_pixel_clock_o <= 1'b0;
      line_sync_out_o <= 1'b1;
      field_sync_out_o <= 1'b1;
      pixel_valid_out_o <= 1'b1;
      vs_cnt_q <= '0;
    end else begin
      tv_pixel_clock_o <= pix_en_q;
      if (pix_en_q) begin
        line_sync_out_o <= (h_q != '0);
        pixel_valid_out_o <= !tv_pop;
        out_odd_q <= odd_q;
        if (tv_pop) begin
          tv_data_lanes_o <= f_word[7:0];
        end
        if (vs_start) begin
          field_sync_out_o <= 1'b0;
          vs_cnt_q <= (tv_field_sync_width_i == '0) ? 8'h00 : tv_field_sync_width_i - 8'h01;
        end else if (vs_cnt_q != '0) begin
          field_sync_out_o <= 1'b0;
          vs_cnt_q <= vs_cnt_q - 8'h01;
        end else begin
          field_sync_out_o <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Parallel access timing
  // ----------------------------------------
  function automatic logic [12:0] ceil_div(input logic [12:0] n, input logic [7:0] d);
    logic [12:0] dd;
    dd = (d == '0) ? 13'h0001 : {5'h00, d};
    ceil_div = (n + dd - 13'h0001) / dd;
  endfunction

  par_state_e st_q;
  logic cur_rd_q;
  logic cur_last_q;
  logic [BE_W-1:0] cur_be_q;
  logic [DATA_W-1:0] cur_data_q;
  logic [13:0] ph_q;
  logic [13:0] cyc_q;
  logic [4:0] pause_q;
  logic [13:0] per_c;
  logic [13:0] wadd_c;
  logic [13:0] up_c;
  logic [13:0] dn_c;
  logic [13:0] len_c;
  logic [13:0] rpt_c;
  logic [12:0] raw_per;

  always_comb begin
    raw_per = ceil_div({1'b0, cur_rd_q ? read_period_setting_i : write_period_setting_i},
      core_clock_period_setting_i);
    per_c = (raw_per == '0) ? 14'h0001 : {1'b0, raw_per};
    wadd_c = cur_rd_q ? 14'(per_c * read_wait_setting_i) : 14'h0000;
    up_c = 14'(ceil_div({1'b0, cur_rd_q ? read_up_setting_i : write_up_setting_i, 1'b0},
      core_clock_period_setting_i) + 13'h0001) >> 1;
    dn_c = (14'(ceil_div({1'b0, cur_rd_q ? read_down_setting_i : write_down_setting_i, 1'b0},
      core_clock_period_setting_i) + 13'h0001) >> 1) + wadd_c;
    len_c = per_c + wadd_c;
    rpt_c = {1'b0, ceil_div({1'b0, read_point_setting_i}, core_clock_period_setting_i)}
      + wadd_c;
  end

  // ----------------------------------------
  // Parallel sequencer
  // ----------------------------------------
  logic par_on;
  logic single;
  logic done_c;
  logic par_pop;

  assign par_on = (if_mode_i == MODE_PAR);
  assign single = (burst_mode_i == BURST_SINGLE);
  assign done_c = (st_q == P_ACCESS) && (ph_q >= len_c - 14'h0001);
  assign par_pop = par_on && f_valid && ((st_q == P_IDLE) || (st_q == P_HOLD)
    || (done_c && !cur_last_q && !single));
  assign f_ready = par_pop || tv_pop;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      st_q <= P_IDLE;
      ph_q <= '0;
      pause_q <= '0;
    end else begin
      unique case (st_q)
        P_IDLE, P_HOLD: begin
          if (par_pop) begin
            st_q <= P_ACCESS;
            ph_q <= '0;
          end
        end
        P_ACCESS: begin
          if (!done_c) begin
            ph_q <= ph_q + 14'h0001;
          end else if (single) begin
            st_q <= P_GAP;
            ph_q <= '0;
          end else if (cur_last_q) begin
            st_q <= P_PAUSE;
            pause_q <= PAUSE_BASE + {1'b0, pause_setting_i};
          end else if (par_pop) begin
            ph_q <= '0;
          end else begin
            st_q <= P_HOLD;
          end
        end
        P_GAP: begin
          ph_q <= ph_q + 14'h0001;
          if (ph_q >= per_c - 14'h0001) begin
            st_q <= P_IDLE;
          end
        end
        P_PAUSE: begin
          pause_q <= pause_q - 5'h01;
          if (pause_q <= 5'h01) begin
            st_q <= P_IDLE;
          end
        end
        default: st_q <= P_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      cur_rd_q <= 1'b0;
      cur_last_q <= 1'b0;
      cur_be_q <= '0;
      cur_data_q <= '0;
      cyc_q <= '0;
    end else if (par_pop) begin
      cur_rd_q <= f_rd;
      cur_last_q <= f_last || single;
      cur_be_q <= f_be;
      cur_data_q <= f_word;
      cyc_q <= '0;
    end else if (st_q == P_ACCESS) begin
      cyc_q <= cyc_q + 14'h0001;
    end
  end

  // ----------------------------------------
  // Control encoding
  // ----------------------------------------
  logic act;
  logic strobe;
  logic cs_raw;
  logic wr_raw;
  logic rd_raw;
  logic bclk_raw;

  assign act = (st_q == P_ACCESS) || (st_q == P_HOLD);
  assign strobe = (st_q == P_ACCESS) && (ph_q >= up_c) && (ph_q < dn_c);

  always_comb begin
    cs_raw = act;
    wr_raw = act && !cur_rd_q;
    rd_raw = act && cur_rd_q;
    bclk_raw = 1'b0;
    if (burst_mode_i == BURST_CLOCKED) begin
      bclk_raw = strobe;
    end else if (!par_type2_i) begin
      cs_raw = strobe;
      if (par_style_68k_i) begin
        rd_raw = act;
      end
    end else if (par_style_68k_i) begin
      rd_raw = strobe;
    end else begin
      wr_raw = strobe && !cur_rd_q;
      rd_raw = strobe && cur_rd_q;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      display_select_n_o <= RST_INACTIVE;
      write_strobe_n_o <= RST_INACTIVE;
      read_strobe_n_o <= RST_INACTIVE;
      burst_clock_out_o <= RST_INACTIVE;
      byte_enable_n_o <= RST_BE_N;
      par_data_o <= '0;
      par_data_oe_o <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_data_o <= '0;
    end else begin
      display_select_n_o <= !(cs_raw ^ signal_polarity_control_i[0]);
      write_strobe_n_o <= !(wr_raw ^ signal_polarity_control_i[1]);
      read_strobe_n_o <= !(rd_raw ^ signal_polarity_control_i[2]);
      burst_clock_out_o <= !(bclk_raw ^ signal_polarity_control_i[3]);
      byte_enable_n_o <= (use_byte_en_i && act) ? ~cur_be_q : RST_BE_N;
      par_data_o <= cur_data_q;
      par_data_oe_o <= act && !cur_rd_q;
      rd_valid_o <= (st_q == P_ACCESS) && cur_rd_q && (ph_q == rpt_c);
      if ((st_q == P_ACCESS) && cur_rd_q && (ph_q == rpt_c)) begin
        rd_data_o <= par_data_i;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking dc @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  AST_LINE_ONE: assert property (
    tv_on && $fell(line_sync_out_o) |-> ##[1:2] $rose(line_sync_out_o))
    else $error("line sync low longer than one pixel");
  AST_VALID_ACTIVE: assert property (
    !pixel_valid_out_o |-> line_sync_out_o)
    else $error("pixel valid outside active interval");
  AST_ODD_EDGE: assert property (
    tv_on && $fell(field_sync_out_o) && out_odd_q |-> $fell(line_sync_out_o))
    else $error("odd field edges do not coincide");
  AST_EVEN_EDGE: assert property (
    tv_on && $fell(field_sync_out_o) && !out_odd_q |-> !$fell(line_sync_out_o))
    else $error("even field edges coincide");
  AST_PAUSE_MIN: assert property (
    (st_q == P_ACCESS) ##1 (st_q == P_PAUSE) |-> (st_q == P_PAUSE) [*4])
    else $error("pause shorter than four cycles");
  AST_GAP_IDLE: assert property (
    st_q == P_GAP |=> display_select_n_o == !signal_polarity_control_i[0]
      && write_strobe_n_o == !signal_polarity_control_i[1]
      && read_strobe_n_o == !signal_polarity_control_i[2])
    else $error("control active during single access gap");
  AST_CLK_END: assert property (
    st_q == P_PAUSE |=> display_select_n_o == !signal_polarity_control_i[0]
      && burst_clock_out_o == !signal_polarity_control_i[3])
    else $error("control active after burst end");
  AST_OFF_QUIET: assert property (
    if_mode_i == MODE_OFF && $past(if_mode_i) == MODE_OFF && st_q == P_IDLE
      |=> line_sync_out_o && field_sync_out_o && pixel_valid_out_o && !par_data_oe_o)
    else $error("outputs active while disabled");
  AST_TYPE2_SEL: assert property (
    st_q == P_ACCESS && par_type2_i && burst_mode_i == BURST_PLAIN
      |=> display_select_n_o == signal_polarity_control_i[0])
    else $error("select dropped inside type 2 burst");
  AST_READ_LEN: assert property (
    done_c && cur_rd_q |-> cyc_q == 14'(per_c * (read_wait_setting_i + 2'd0 + 14'd1)) - 14'd1)
    else $error("read access length wrong");

  COV_TV_FIELD: cover property (tv_on && $fell(field_sync_out_o) && !out_odd_q);
  COV_BURST: cover property ((st_q == P_ACCESS) ##1 (st_q == P_PAUSE));
  COV_SINGLE: cover property (st_q == P_GAP);
  COV_READ_WAIT: cover property (rd_valid_o && read_wait_setting_i == 2'd3);
endmodule

// ==== bench/display_model.sv ====
module display_model (
  // Clock
  input wire logic clock_i,
  // Port pins from the block, slow setting from the bench
  input wire logic display_select_n_i,
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  input wire logic slow_i,
  // Read data back to the block
  output logic [15:0] par_data_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Panel read port
  // ----------------------------------------
  logic [15:0] value_q = 16'hc3a0;
  logic [15:0] last_q = 16'h0000;
  logic reading_q = 1'b0;
  logic reading;

  assign reading = !display_select_n_i && !read_strobe_n_i && write_strobe_n_i;

  // Slow panel answers only from the second cycle of the read strobe
  always_comb
    par_data_o = (reading && (!slow_i || reading_q)) ? value_q : ~last_q;

  // Next word after each finished read
  always @(posedge clock_i) begin
    if (reading) last_q <= value_q;
    if (reading_q && !reading) value_q <= value_q + 16'h0001;
    reading_q <= reading;
  end
endmodule

// ==== bench/display_port_tb.sv ====
module display_port_tb
  import dispif_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock_i, reset_n_i, style, typ2, use_be, src_valid, src_read, src_last, slow;
  logic [1:0] mode, burst, rdwait, be;
  logic [3:0] pol, pause;
  logic [11:0] wper, rpt;
  logic [10:0] wdown, wup, rup, rdn;
  logic [7:0] cper, fsw;
  logic qual_n;
  logic [15:0] src_data, par_in;
  logic src_ready_o, rd_valid_o, tv_pixel_clock_o, line_sync_out_o, field_sync_out_o;
  logic pixel_valid_out_o, display_select_n_o, write_strobe_n_o, read_strobe_n_o;
  logic burst_clock_out_o, par_data_oe_o;
  logic [15:0] rd_data_o, par_data_o;
  logic [17:10] tv_data_lanes_o;
  logic [1:0] byte_enable_n_o;
  logic [31:0] seed = 32'h3c6acc4c;
  logic [15:0] wq[$], rq[$];
  logic [7:0] tq[$];
  int n_errors = 0, compares = 0, rw = 0, exp_rw = 1, gap_run = 0, last_gap = 0, ls = 0;
  int odd_n = 0, even_n = 0, ticks = 0, tvc = 0, rd_n = 0;
  logic lprev = 1'b1, fprev = 1'b1, wprev = 1'b1;

  // Data qualifier of the selected port type
  assign qual_n = (burst == BURST_CLOCKED) ? burst_clock_out_o : !typ2 ? display_select_n_o
    : style ? read_strobe_n_o : write_strobe_n_o;

  display_port display_port_i (.clock_i(clock_i), .reset_n_i(reset_n_i), .if_mode_i(mode),
    .par_style_68k_i(style), .par_type2_i(typ2), .burst_mode_i(burst), .use_byte_en_i(use_be),
    .signal_polarity_control_i(pol), .pause_setting_i(pause), .read_wait_setting_i(rdwait),
    .core_clock_period_setting_i(cper), .read_period_setting_i(12'h004),
    .write_period_setting_i(wper), .read_up_setting_i(rup), .read_down_setting_i(rdn),
    .write_up_setting_i(wup), .write_down_setting_i(wdown), .read_point_setting_i(rpt),
    .tv_line_total_i(12'h010), .tv_active_first_i(12'h002), .tv_active_count_i(12'h008),
    .tv_field_lines_i(11'h004), .tv_field_sync_width_i(fsw), .src_valid_i(src_valid),
    .src_ready_o(src_ready_o), .src_data_i(src_data), .src_read_i(src_read),
    .src_last_i(src_last), .src_be_i(be), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
    .tv_pixel_clock_o(tv_pixel_clock_o), .line_sync_out_o(line_sync_out_o),
    .field_sync_out_o(field_sync_out_o), .pixel_valid_out_o(pixel_valid_out_o),
    .tv_data_lanes_o(tv_data_lanes_o), .display_select_n_o(display_select_n_o),
    .write_strobe_n_o(write_strobe_n_o), .read_strobe_n_o(read_strobe_n_o),
    .burst_clock_out_o(burst_clock_out_o), .byte_enable_n_o(byte_enable_n_o),
    .par_data_i(par_in), .par_data_o(par_data_o), .par_data_oe_o(par_data_oe_o));

  display_model display_model_i (.clock_i(clock_i), .display_select_n_i(display_select_n_o),
    .read_strobe_n_i(read_strobe_n_o), .write_strobe_n_i(write_strobe_n_o), .slow_i(slow),
    .par_data_o(par_in));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic results();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // Offer one entry and hold it until the FIFO takes it
  task automatic push(input logic [15:0] d, input logic rd, input logic last);
    int k;
    seed = lfsr(seed);
    src_valid <= 1'b1;
    src_data <= d;
    src_read <= rd;
    src_last <= last;
    be <= seed[1:0];
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (src_ready_o !== 1'b1 && k < 300);
    if (k >= 300) begin
      n_errors++;
      results();
    end
  endtask

  // ----------------------------------------
  // Clock and output monitor
  // ----------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    if (reset_n_i) begin
      if (!qual_n && wprev && par_data_oe_o === 1'b1 && mode == MODE_PAR)
        check(par_data_o, wq.size() ? wq.pop_front() : 'x, "write data");
      wprev <= qual_n;
      if (!read_strobe_n_o && !style) rw++;
      else if (rw > 0) begin
        check(rw, exp_rw, "read strobe width");
        rw = 0;
      end
      if (rd_valid_o === 1'b1)
        check(rd_data_o, rq.size() ? rq.pop_front() : 'x, "read data");
      if (display_select_n_o) gap_run++;
      else if (gap_run > 0) begin
        last_gap = gap_run;
        gap_run = 0;
      end
      if (mode == MODE_TV) tvc++;
      if (tv_pixel_clock_o) begin
        ticks++;
        if (!pixel_valid_out_o) begin
          check(line_sync_out_o, 1'b1, "data outside active interval");
          check(tv_data_lanes_o, tq.size() ? tq.pop_front() : 'x,
            "tv component");
        end
        if (!line_sync_out_o) ls++;
        else if (ls > 0) begin
          check(ls, 1, "line sync width");
          ls = 0;
        end
        if (fprev && !field_sync_out_o && lprev && !line_sync_out_o) odd_n++;
        else if (fprev && !field_sync_out_o) even_n++;
        lprev <= line_sync_out_o;
        fprev <= field_sync_out_o;
      end
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset_n_i = 1'b0;
    {style, typ2, use_be, src_valid, src_read, src_last, slow} = 7'h00;
    {mode, burst, rdwait, be, pol, pause} = 16'h0000;
    wper = 12'h003;
    wdown = 11'h002;
    {cper, fsw, rup, rdn, wup, rpt} = {8'h01, 8'h01, 11'h001, 11'h002, 11'h001, 12'h002};
    src_data = 16'h0000;
    repeat (12) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(posedge clock_i);
    @(posedge clock_i);
    check({display_select_n_o, write_strobe_n_o, read_strobe_n_o, line_sync_out_o,
      field_sync_out_o, pixel_valid_out_o}, 6'h3f, "idle controls");
    // Fill until refused, then drain as two bursts with minimum and maximum pause
    typ2 <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      pause <= p ? 4'hf : 4'h0;
      for (int i = 0; i < 8; i++) begin
        wq.push_back(seed[15:0]);
        push(seed[15:0], 1'b0, i == 3 || i == 7);
      end
      repeat (4) @(posedge clock_i);
      check(src_ready_o, 1'b0, "full FIFO refuses");
      src_valid <= 1'b0;
      mode <= MODE_PAR;
      repeat (300) @(posedge clock_i);
      check(last_gap >= 4 + 15 * p && last_gap <= 8 + 15 * p, 1'b1, "burst pause");
      check(wq.size(), 0, "writes drained");
      mode <= MODE_OFF;
    end
    // Every style, type and burst mode, random write timing
    for (int c = 0; c < 12; c++) begin
      seed = lfsr(seed);
      style <= c[0];
      typ2 <= c[1];
      burst <= 2'(c / 4);
      use_be <= seed[4];
      cper <= 8'(1 + seed[6]);
      wup <= 11'(1 + seed[6]);
      wper <= 12'((3 + seed[3:2]) * (1 + seed[6]));
      wdown <= 11'((2 + seed[5]) * (1 + seed[6]));
      mode <= MODE_PAR;
      for (int i = 0; i < 3; i++) begin
        wq.push_back(seed[31:16]);
        push(seed[31:16], 1'b0, i == 2);
      end
      src_valid <= 1'b0;
      repeat (150) @(posedge clock_i);
      check({display_select_n_o, write_strobe_n_o, read_strobe_n_o, burst_clock_out_o}, 4'hf,
        "controls after burst");
      check(wq.size(), 0, "writes done");
    end
    pol <= 4'hf;
    repeat (3) @(posedge clock_i);
    check({display_select_n_o, write_strobe_n_o, read_strobe_n_o}, 3'h0,
      "inverted idle");
    pol <= 4'h0;
    cper <= 8'h01;
    repeat (2) @(posedge clock_i);
    // Reads without and with wait states, slow panel on the long one
    {style, typ2, burst} <= 4'b0100;
    for (int w = 0; w < 2; w++) begin
      rdwait <= 2'(w);
      slow <= w[0];
      exp_rw = 1 + 4 * w;
      for (int i = 0; i < 3; i++) begin
        rq.push_back(16'hc3a0 + 16'(rd_n));
        rd_n++;
        push(16'h0000, 1'b1, i == 2);
      end
      src_valid <= 1'b0;
      repeat (200) @(posedge clock_i);
      check(rq.size(), 0, "reads returned");
    end
    // TV stream
    mode <= MODE_TV;
    fsw <= 8'h02;
    tvc = 0;
    ticks = 0;
    for (int i = 0; i < 40; i++) begin
      tq.push_back(seed[7:0]);
      push({8'h00, seed[7:0]}, 1'b0, 1'b0);
    end
    src_valid <= 1'b0;
    repeat (400) @(posedge clock_i);
    check(tq.size(), 0, "tv bytes shown");
    check(odd_n > 0 && even_n > 0, 1'b1, "field edges");
    check(ticks * 50 + 100 >= tvc * 27 && ticks * 50 <= tvc * 27 + 100, 1'b1,
      "pixel rate");
    check(line_sync_out_o !== 1'bx && ls <= 1, 1'b1, "line sync active low");
    results();
  end
endmodule
